// ---- inc/sac_regs.vh ----
// register map, field positions and timing constants of the converter control
// assumes word addressing on a 16-bit processor data path
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// ================================================================
// register word addresses
`define SAC_ADDR_W          16
`define SAC_DATA_W          16
`define SAC_OFF_CTRL        16'h7012
`define SAC_OFF_RESULT      16'h7014
`define SAC_OFF_CLKCTRL     16'h7016
`define SAC_OFF_PINCTRL     16'h7018
`define SAC_OFF_GPOCTRL     16'h701A

// ================================================================
// converter_control fields
`define SAC_CTRL_START      0
`define SAC_CTRL_CONT       1
`define SAC_CTRL_CHAN_LO    2
`define SAC_CTRL_CHAN_HI    4
`define SAC_CTRL_NOTE_LO    5
`define SAC_CTRL_NOTE_HI    6
`define SAC_NOTE_POLL       2'h0
`define SAC_NOTE_IRQ        2'h1
`define SAC_NOTE_DMA        2'h2
`define SAC_CHAN_LAST       3'h5

// ================================================================
// conversion_result fields
`define SAC_RES_W           10
`define SAC_RES_VALID       14
`define SAC_RES_BUSY        15

// ================================================================
// reference_and_pin_control fields
`define SAC_PIN_REF_LO      0
`define SAC_PIN_REF_HI      1
`define SAC_PIN_PWRDN       2
`define SAC_PIN_GPO_LO      4
`define SAC_PIN_GPO_HI      7
`define SAC_REF_INT_1V0     2'h0
`define SAC_REF_INT_0V8     2'h1
`define SAC_REF_EXT_SUPPLY  2'h2
`define SAC_PIN_RESET       16'h0004
`define SAC_PWRDN_RESET     1'b1
`define SAC_NUM_PINS        4

// ================================================================
// conversion clock and sequence timing
`define SAC_SYS_HZ          50000000
`define SAC_CONV_MAX_HZ     2000000
`define SAC_DIV_MIN         ((`SAC_SYS_HZ + `SAC_CONV_MAX_HZ - 1) / `SAC_CONV_MAX_HZ)
`define SAC_DIV_W           8
`define SAC_DIV_RESET       8'h19
`define SAC_CONV_CYCLES     6'h20
`define SAC_TICK_SAMPLE     6'h00
`define SAC_TICK_FIRST      6'h01
`define SAC_TICK_LAST_BIT   6'h0B

`endif

// ---- core/sac_buf.v ----
// two-entry result buffer with valid and ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module sac_buf (
	input  wire         i_clock,
	input  wire         i_rst_n,
	input  wire [9:0]   i_in_data,
	input  wire         i_in_valid,
	output wire         o_in_ready,
	output wire [9:0]   o_out_data,
	output wire         o_out_valid,
	input  wire         i_out_ready
);

	reg  [9:0] slot0_ff;
	reg  [9:0] slot1_ff;
	reg  [1:0] count_ff;
	wire       push;
	wire       pop;

	// ================================================================
	// handshakes; full refuses input so the source stalls
	assign o_in_ready  = (count_ff != 2'h2);
	assign o_out_valid = (count_ff != 2'h0);
	assign o_out_data  = slot0_ff;
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// ================================================================
	// slot0 is always the head
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slot0_ff <= 10'h000;
			slot1_ff <= 10'h000;
			count_ff <= 2'h0;
		end else begin
			case ({push, pop})
				2'b10: begin
					if (count_ff == 2'h0) begin
						slot0_ff <= i_in_data;
					end else begin
						slot1_ff <= i_in_data;
					end
					count_ff <= count_ff + 2'h1;
				end
				2'b01: begin
					slot0_ff <= slot1_ff;
					count_ff <= count_ff - 2'h1;
				end
				2'b11: begin
					// push only possible below full, so count stays
					if (count_ff == 2'h1) begin
						slot0_ff <= i_in_data;
					end else begin
						slot0_ff <= slot1_ff;
						slot1_ff <= i_in_data;
					end
				end
				default: begin
					count_ff <= count_ff;
				end
			endcase
		end
	end

endmodule // sac_buf

`default_nettype wire

// ---- core/sac_top.v ----
// converter control: register file, conversion clock, sequencer, pin control
// assumes an analog core that samples on o_sample_hold and compares against o_dac_code
// Operation
// RQ1 - results are 10-bit words; rate bounded to 62.5 ksps by clock limits
// RQ2 - one conversion spans 32 conversion clock periods, clock at most 2 MHz
// RQ3 - six selectable channels mapped onto four analog pins
// RQ4 - each analog pin may instead be a digital general output
// RQ5 - single mode converts once per request; continuous restarts immediately
// RQ6 - completion signalled by interrupt, polled status, or DMA event
// RQ7 - software powers the converter down and up via a control bit
// RQ8 - reference selects internal 1 V, internal 0.8 V or analog supply
// RQ9 - result updates only on completion; busy from start until result available
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.vh"

module sac_top (
	input  wire                     i_clock,
	input  wire                     i_rst_n,
	input  wire [`SAC_ADDR_W-1:0]   i_addr,
	input  wire [`SAC_DATA_W-1:0]   i_wdata,
	input  wire                     i_wr,
	input  wire                     i_rd,
	output reg  [`SAC_DATA_W-1:0]   o_rdata,
	input  wire                     i_cmp_above,
	output reg  [`SAC_RES_W-1:0]    o_dac_code,
	output reg                      o_sample_hold,
	output reg  [2:0]               o_chan_sel,
	output reg  [1:0]               o_ref_sel,
	output reg                      o_pwr_down,
	output reg  [3:0]               o_gpo_out,
	output reg  [3:0]               o_gpo_oe_n,
	output reg                      o_busy,
	output reg                      o_irq,
	output reg                      o_dma_req
);

	// ================================================================
	// decode helper
	function hit;
		input [`SAC_ADDR_W-1:0] addr;
		input [`SAC_ADDR_W-1:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	localparam ST_IDLE = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_HOLD = 2'h2;

	reg                     cont_ff;
	reg  [2:0]              chan_ff;
	reg  [1:0]              note_ff;
	reg  [`SAC_DIV_W-1:0]   div_ff;
	reg  [1:0]              ref_ff;
	reg                     pwrdn_ff;
	reg  [3:0]              gpo_en_ff;
	reg  [3:0]              gpo_val_ff;
	reg  [1:0]              state_ff;
	reg  [1:0]              nxt_state;
	reg  [`SAC_DIV_W-1:0]   divcnt_ff;
	reg  [5:0]              tick_ff;
	reg  [`SAC_RES_W-1:0]   sar_ff;
	reg  [`SAC_RES_W-1:0]   trial_ff;
	wire                    wr_ctrl;
	wire                    rd_res;
	wire                    start_req;
	wire                    conv_tick;
	wire                    conv_end;
	wire                    buf_in_ready;
	wire [`SAC_RES_W-1:0]   buf_data;
	wire                    buf_valid;
	wire                    push_res;
	wire [`SAC_DIV_W-1:0]   div_min;
	wire [31:0]             div_min_full;

	// ceiling quotient is small, only the divider's width is kept
	assign div_min_full = `SAC_DIV_MIN;
	assign div_min   = div_min_full[`SAC_DIV_W-1:0];
	assign wr_ctrl   = i_wr & hit(i_addr, `SAC_OFF_CTRL);
	assign rd_res    = i_rd & hit(i_addr, `SAC_OFF_RESULT);
	assign start_req = wr_ctrl & i_wdata[`SAC_CTRL_START] & ~pwrdn_ff;
	assign conv_tick = (state_ff == ST_CONV) & (divcnt_ff == div_ff - 8'h01);
	assign conv_end  = conv_tick & (tick_ff == `SAC_CONV_CYCLES - 6'h01);
	// a finished result waits in HOLD while the buffer is full
	assign push_res  = ((state_ff == ST_HOLD) | conv_end) & buf_in_ready; // see RQ9

	// ================================================================
	// configuration registers
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cont_ff    <= 1'b0;
			chan_ff    <= 3'h0;
			note_ff    <= `SAC_NOTE_POLL;
			div_ff     <= `SAC_DIV_RESET;
			ref_ff     <= `SAC_REF_INT_1V0;
			pwrdn_ff   <= `SAC_PWRDN_RESET;
			gpo_en_ff  <= 4'h0;
			gpo_val_ff <= 4'h0;
		end else if (i_wr) begin
			if (hit(i_addr, `SAC_OFF_CTRL)) begin
				cont_ff <= i_wdata[`SAC_CTRL_CONT]; // see RQ5
				// channel codes beyond the sixth are ignored
				if (i_wdata[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO] <= `SAC_CHAN_LAST) begin
					chan_ff <= i_wdata[`SAC_CTRL_CHAN_HI:`SAC_CTRL_CHAN_LO]; // see RQ3
				end
				note_ff <= i_wdata[`SAC_CTRL_NOTE_HI:`SAC_CTRL_NOTE_LO]; // see RQ6
			end
			if (hit(i_addr, `SAC_OFF_CLKCTRL)) begin
				// clamp keeps the conversion clock at or below its ceiling
				if (i_wdata[`SAC_DIV_W-1:0] < div_min) begin
					div_ff <= div_min; // see RQ2
				end else begin
					div_ff <= i_wdata[`SAC_DIV_W-1:0];
				end
			end
			if (hit(i_addr, `SAC_OFF_PINCTRL)) begin
				if (i_wdata[`SAC_PIN_REF_HI:`SAC_PIN_REF_LO] <= `SAC_REF_EXT_SUPPLY) begin
					ref_ff <= i_wdata[`SAC_PIN_REF_HI:`SAC_PIN_REF_LO]; // see RQ8
				end
				pwrdn_ff  <= i_wdata[`SAC_PIN_PWRDN]; // see RQ7
				gpo_en_ff <= i_wdata[`SAC_PIN_GPO_HI:`SAC_PIN_GPO_LO]; // see RQ4
			end
			if (hit(i_addr, `SAC_OFF_GPOCTRL)) begin
				gpo_val_ff <= i_wdata[`SAC_NUM_PINS-1:0];
			end
		end
	end

	// ================================================================
	// sequencer next state
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start_req) begin
					nxt_state = ST_CONV; // see RQ5
				end
			end
			ST_CONV: begin
				if (pwrdn_ff) begin
					nxt_state = ST_IDLE; // see RQ7
				end else if (conv_end & ~buf_in_ready) begin
					nxt_state = ST_HOLD;
				end else if (conv_end) begin
					nxt_state = cont_ff ? ST_CONV : ST_IDLE; // see RQ5
				end
			end
			ST_HOLD: begin
				if (pwrdn_ff) begin
					nxt_state = ST_IDLE;
				end else if (buf_in_ready) begin
					nxt_state = cont_ff ? ST_CONV : ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// ================================================================
	// conversion clock divider, tick counter and bit decisions
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff  <= ST_IDLE;
			divcnt_ff <= 8'h00;
			tick_ff   <= 6'h00;
			sar_ff    <= 10'h000;
			trial_ff  <= 10'h000;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state == ST_CONV && state_ff != ST_CONV) begin
				divcnt_ff <= 8'h00;
				tick_ff   <= `SAC_TICK_SAMPLE;
				sar_ff    <= 10'h000;
				trial_ff  <= 10'h000;
			end else if (state_ff == ST_CONV) begin
				if (conv_tick) begin
					divcnt_ff <= 8'h00;
					// 32 periods, then wrap for back-to-back runs
					tick_ff <= (tick_ff == `SAC_CONV_CYCLES - 6'h01) ? 6'h00 : tick_ff + 6'h01; // see RQ2
					if (tick_ff == `SAC_TICK_SAMPLE) begin
						sar_ff   <= 10'h000;
						trial_ff <= 10'h000;
					end else if (tick_ff == `SAC_TICK_FIRST) begin
						trial_ff <= 10'h200; // msb first
					end else if (tick_ff <= `SAC_TICK_LAST_BIT) begin
						// keep the trial bit when the input sits above the code
						if (i_cmp_above) begin
							sar_ff <= sar_ff | trial_ff; // see RQ1
						end
						trial_ff <= trial_ff >> 1;
					end
				end else begin
					divcnt_ff <= divcnt_ff + 8'h01;
				end
			end
		end
	end

	// ================================================================
	// result buffer; a reader stall stalls the sequencer, nothing lost
	sac_buf u_buf (
		.i_clock     (i_clock),
		.i_rst_n     (i_rst_n),
		.i_in_data   (sar_ff),
		.i_in_valid  (push_res),
		.o_in_ready  (buf_in_ready),
		.o_out_data  (buf_data),
		.o_out_valid (buf_valid),
		.i_out_ready (rd_res)
	);

	// ================================================================
	// read data; a result read pops the head word
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 16'h0000;
		end else if (i_rd) begin
			if (hit(i_addr, `SAC_OFF_CTRL)) begin
				o_rdata <= {9'h000, note_ff, chan_ff, cont_ff, 1'b0};
			end else if (hit(i_addr, `SAC_OFF_RESULT)) begin
				// an empty buffer reads a zero result field with valid clear, never an older stale word
				o_rdata <= {o_busy, buf_valid, 4'h0, (buf_valid ? buf_data : 10'h000)}; // see RQ6
			end else if (hit(i_addr, `SAC_OFF_CLKCTRL)) begin
				o_rdata <= {8'h00, div_ff};
			end else if (hit(i_addr, `SAC_OFF_PINCTRL)) begin
				o_rdata <= {8'h00, gpo_en_ff, 1'b0, pwrdn_ff, ref_ff};
			end else if (hit(i_addr, `SAC_OFF_GPOCTRL)) begin
				o_rdata <= {12'h000, gpo_val_ff};
			end else begin
				o_rdata <= 16'h0000;
			end
		end
	end

	// ================================================================
	// analog core controls and completion events
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dac_code    <= 10'h000;
			o_sample_hold <= 1'b0;
			o_chan_sel    <= 3'h0;
			o_ref_sel     <= `SAC_REF_INT_1V0;
			o_pwr_down    <= `SAC_PWRDN_RESET;
			o_busy        <= 1'b0;
			o_irq         <= 1'b0;
			o_dma_req     <= 1'b0;
		end else begin
			o_dac_code    <= sar_ff | trial_ff;
			o_sample_hold <= (state_ff == ST_CONV) & (tick_ff == `SAC_TICK_SAMPLE);
			o_chan_sel    <= chan_ff; // see RQ3
			o_ref_sel     <= ref_ff; // see RQ8
			o_pwr_down    <= pwrdn_ff; // see RQ7
			o_busy        <= (nxt_state != ST_IDLE); // see RQ9
			o_irq         <= push_res & (note_ff == `SAC_NOTE_IRQ); // see RQ6
			o_dma_req     <= push_res & (note_ff == `SAC_NOTE_DMA); // see RQ6
		end
	end

	// ================================================================
	// per-pin general output; enable low means the pin is driven
	genvar gi;
	generate
		for (gi = 0; gi < `SAC_NUM_PINS; gi = gi + 1) begin : g_pin
			always @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_gpo_out[gi]  <= 1'b0;
					o_gpo_oe_n[gi] <= 1'b1;
				end else begin
					o_gpo_out[gi]  <= gpo_val_ff[gi];
					o_gpo_oe_n[gi] <= ~gpo_en_ff[gi]; // see RQ4
				end
			end
		end
	endgenerate

endmodule // sac_top

`default_nettype wire

// ---- testbench/sac_top_asserts.sv ----
// port checker for the converter control
// assumes the bind below onto sac_top, one clock, reset active low
`timescale 1ns/1ps
`default_nettype none
`include "sac_regs.vh"

module sac_chk (
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic        i_cmp_above,
	input wire logic [9:0]  o_dac_code,
	input wire logic        o_sample_hold,
	input wire logic [2:0]  o_chan_sel,
	input wire logic [1:0]  o_ref_sel,
	input wire logic        o_pwr_down,
	input wire logic [3:0]  o_gpo_out,
	input wire logic [3:0]  o_gpo_oe_n,
	input wire logic        o_busy,
	input wire logic        o_irq,
	input wire logic        o_dma_req
);
	// ================================================================
	// properties, all in the one clock domain
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	// the power-down output trails its control bit by one edge
	a_start_busy: assert property (
		i_wr && i_addr == `SAC_OFF_CTRL && i_wdata[0] && !o_busy ##1 !o_pwr_down |-> o_busy)
		else $error("start did not raise busy");
	a_start_refused: assert property (
		i_wr && i_addr == `SAC_OFF_CTRL && !o_busy ##1 o_pwr_down |-> !o_busy)
		else $error("start taken while powered down");
	a_busy_span: assert property ($rose(o_busy) |-> o_busy [*8])
		else $error("conversion ended too soon");
	a_irq_pulse: assert property (o_irq |=> !o_irq [*8])
		else $error("interrupt pulse too long");
	a_dma_pulse: assert property (o_dma_req |=> !o_dma_req [*8])
		else $error("dma pulse too long");
	a_notify_excl: assert property (!(o_irq && o_dma_req))
		else $error("two notifications at once");
	a_sample_busy: assert property ($rose(o_sample_hold) |-> o_busy)
		else $error("sampling while idle");
	a_pwr_abort: assert property (o_pwr_down |-> !o_busy)
		else $error("busy while powered down");
	a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data moved without a read");
	a_chan_range: assert property (o_chan_sel <= 3'h5)
		else $error("channel out of range");
	a_ref_range: assert property (o_ref_sel != 2'h3)
		else $error("reserved reference code");
	a_gpo_write: assert property (
		i_wr && i_addr == `SAC_OFF_GPOCTRL |-> ##2 o_gpo_out == $past(i_wdata[3:0], 2))
		else $error("general output not updated");
endmodule // sac_chk

bind sac_top sac_chk i_sac_chk (
	.i_clock       (i_clock),
	.i_rst_n       (i_rst_n),
	.i_addr        (i_addr),
	.i_wdata       (i_wdata),
	.i_wr          (i_wr),
	.i_rd          (i_rd),
	.o_rdata       (o_rdata),
	.i_cmp_above   (i_cmp_above),
	.o_dac_code    (o_dac_code),
	.o_sample_hold (o_sample_hold),
	.o_chan_sel    (o_chan_sel),
	.o_ref_sel     (o_ref_sel),
	.o_pwr_down    (o_pwr_down),
	.o_gpo_out     (o_gpo_out),
	.o_gpo_oe_n    (o_gpo_oe_n),
	.o_busy        (o_busy),
	.o_irq         (o_irq),
	.o_dma_req     (o_dma_req)
);

`default_nettype wire

// ---- testbench/sac_ana.sv ----
// analog side: channel levels and the comparator
// assumes it is clocked with the converter control
`timescale 1ns/1ps
`default_nettype none

module sac_ana (
	input  wire logic       i_clock,
	input  wire logic [9:0] i_dac_code,
	input  wire logic [2:0] i_chan_sel,
	input  wire logic       i_pwr_down,
	output wire logic       o_cmp_above
);
	logic flip_ff = 1'b0;

	// ================================================================
	// comparator: a powered-down core gives garbage, not the last answer
	always @(posedge i_clock) begin
		flip_ff <= ~flip_ff;
	end
	// level sits half a code above {chan,2B}, so no tie at equality
	assign o_cmp_above = i_pwr_down ? flip_ff
		: (i_dac_code <= {i_chan_sel, 7'h2B});
endmodule // sac_ana

`default_nettype wire

// ---- testbench/sac_top_bench.sv ----
// self-checking bench for the converter control
// assumes sac_top with the analog model on its comparator input
`timescale 1ns/1ps
`default_nettype none

module sac_top_bench;
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [15:0] i_addr  = 16'h0000;
	logic [15:0] i_wdata = 16'h0000;
	logic        i_wr    = 1'b0;
	logic        i_rd    = 1'b0;
	wire  [15:0] o_rdata;
	wire  [9:0]  dac;
	wire  [2:0]  o_chan_sel;
	wire  [1:0]  o_ref_sel;
	wire  [3:0]  o_gpo_out;
	wire  [3:0]  o_gpo_oe_n;
	wire         cmp, o_sample_hold, o_pwr_down, o_busy, o_irq, o_dma_req;
	int          failures = 0;
	int          n_tests = 0;
	int          n_irq = 0;
	int          n_dma = 0;
	int          e_irq = 0;
	int          e_dma = 0;
	logic [15:0] rv;

	always #10 i_clock = ~i_clock;

	sac_top i_sac_top (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cmp_above(cmp), .o_dac_code(dac), .o_sample_hold(o_sample_hold),
		.o_chan_sel(o_chan_sel), .o_ref_sel(o_ref_sel), .o_pwr_down(o_pwr_down),
		.o_gpo_out(o_gpo_out), .o_gpo_oe_n(o_gpo_oe_n), .o_busy(o_busy),
		.o_irq(o_irq), .o_dma_req(o_dma_req));
	sac_ana i_sac_ana (.i_clock(i_clock), .i_dac_code(dac), .i_chan_sel(o_chan_sel),
		.i_pwr_down(o_pwr_down), .o_cmp_above(cmp));

	// ================================================================
	// notification pulses are counted, not waited for
	always @(posedge i_clock) begin
		if (o_irq === 1'b1) n_irq++;
		if (o_dma_req === 1'b1) n_dma++;
	end

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clock);
		#1;
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(posedge i_clock);
		#1;
		i_wr = 1'b0;
		// registered outputs follow the write one edge later
		@(posedge i_clock);
		#1;
	endtask

	// read data is registered at the strobe's edge
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge i_clock);
		#1;
		i_addr = a;
		i_rd = 1'b1;
		@(posedge i_clock);
		#1;
		i_rd = 1'b0;
		d = o_rdata;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask

	// bounded wait: a stuck busy shows as a mismatch
	task automatic wait_idle;
		int k;
		k = 0;
		while (o_busy !== 1'b0 && k < 2000) begin
			@(posedge i_clock);
			#1;
			k++;
		end
		chk("idle", 16'h0, {15'h0, o_busy});
	endtask

	task automatic test_done;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#(20 * 40000);
		failures++;
		test_done();
	end

	// ================================================================
	// test sequence
	initial begin
		repeat (4) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		chk("oe_n", 16'hF, {12'h0, o_gpo_oe_n});
		rd(16'h7018, rv);
		chk("pinctrl", 16'h0004, rv);
		rd(16'h7016, rv);
		chk("clkctrl", 16'h0019, rv);
		rd(16'h7013, rv);
		chk("unmapped", 16'h0, rv);
		wr(16'h7012, 16'h0001);
		chk("busy", 16'h0, {15'h0, o_busy});
		$display("test reset done");
		// code 3 is reserved and must leave the reference at 2
		for (int r = 0; r < 4; r++) begin
			wr(16'h7018, {14'h0014, r[1:0]});
			chk("ref", {14'h0, (r == 3) ? 2'h2 : r[1:0]}, {14'h0, o_ref_sel});
		end
		chk("oe_n", 16'hA, {12'h0, o_gpo_oe_n});
		wr(16'h701A, 16'h000B);
		chk("gpo", 16'hB, {12'h0, o_gpo_out});
		wr(16'h7016, 16'h0030);
		rd(16'h7016, rv);
		chk("clkctrl", 16'h0030, rv);
		wr(16'h7016, 16'h0005);
		rd(16'h7016, rv);
		chk("clkctrl", 16'h0019, rv);
		$display("test registers done");
		// every channel, notify mode cycling poll, interrupt, dma
		for (int c = 0; c < 6; c++) begin
			wr(16'h7012, {9'h000, 2'(c % 3), c[2:0], 2'b01});
			e_irq += (c % 3 == 1);
			e_dma += (c % 3 == 2);
			chk("chan", {13'h0, c[2:0]}, {13'h0, o_chan_sel});
			rd(16'h7014, rv);
			chk("early", 16'h8000, rv);
			wait_idle();
			rd(16'h7014, rv);
			chk("result", {6'h10, c[2:0], 7'h2B}, rv);
			chk("irq", e_irq[15:0], n_irq[15:0]);
			chk("dma", e_dma[15:0], n_dma[15:0]);
		end
		$display("test single done");
		// continuous: two unread results stall the sequencer, busy held
		wr(16'h7012, 16'h0017);
		repeat (3000) @(posedge i_clock);
		#1;
		chk("stall", 16'h1, {15'h0, o_busy});
		rd(16'h7014, rv);
		chk("cont", 16'hC2AB, rv);
		wr(16'h7012, 16'h0014);
		// one pop frees room for the conversion still running
		rd(16'h7014, rv);
		chk("cont", 16'hC2AB, rv);
		wait_idle();
		rv = 16'h4000;
		for (int k = 0; k < 4 && rv[14]; k++) begin
			rd(16'h7014, rv);
			if (rv[14])
				chk("drain", 16'h42AB, rv);
		end
		chk("empty", 16'h0, rv);
		$display("test continuous done");
		// power-down mid conversion aborts it with no result
		wr(16'h7012, 16'h0001);
		repeat (100) @(posedge i_clock);
		wr(16'h7018, 16'h0054);
		wait_idle();
		rd(16'h7014, rv);
		chk("abort", 16'h0, rv);
		$display("test power done");
		test_done();
	end
endmodule // sac_top_bench

`default_nettype wire
